// *** rtl/ebi_pins.v ***
// Purpose: external bus pin sequencer for rom, sram and i/o regions
// Assumes: mclk is the internal bus clock, reset synchronous active high
// Notes:   one external cycle at a time, launched from the register window
//
// Summary of operation
// - io clock at 1/1, 1/2, 1/3 or 1/4 of mclk, chosen by boot strap.
// - clearing the clock enable stops the io clock and holds it high.
// - active-low strobe latches the high address bits from the address pins.
// - eight active-low chip selects, one per external region.
// - active-low output enable drives during reads so the device returns data.
// - active-low write strobe pulses during write cycles.
// - byte-enable mode marks valid lanes on reads and writes.
// - byte-write-enable mode marks lanes only on writes, idle on reads.
// - a 16-bit region uses only the lower two lane signals.
// - an 8-bit region uses only the lowest lane signal.
// - lane n qualifies data bits 8n+7 down to 8n.
// - lane mode comes from a data-pin strap plus a per-channel select bit.
// - pulled-up ready pin paces cycles, driven by the block or the device.
`timescale 1ns/10ps
`include "ebi_pins_consts.vh"

module ebi_pins (
  input  wire        mclk,
  input  wire        reset,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [1:0]  strap_clk_ratio,
  input  wire        strap_lane_mode,
  output wire        ext_io_clock,
  output reg  [15:0] addr_pin,
  output reg         high_addr_latch_n,
  output reg  [7:0]  chip_sel_n,
  output reg         out_en_n,
  output reg         wr_strobe_n,
  output reg  [3:0]  byte_lane_en_n,
  input  wire [31:0] data_in,
  output reg  [31:0] data_out,
  output reg         data_oe,
  input  wire        ack_in,
  output wire        ack_out,
  output reg         ack_oe
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_LATCH = 3'h1;
  localparam [2:0] ST_SETUP = 3'h2;
  localparam [2:0] ST_STRB  = 3'h3;
  localparam [2:0] ST_HOLD  = 3'h4;

  // merge a bus write into a register under its byte strobes
  function [31:0] wmerge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer k;
    begin
      wmerge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          wmerge[8*k +: 8] = new_v[8*k +: 8];
        end
      end
    end
  endfunction

  // active lanes for a region width; lane n carries bits 8n+7..8n
  function [3:0] lane_fit;
    input [1:0] width;
    input [3:0] mask;
    begin
      case (width)
        `EBI_W16: lane_fit = {2'h0, mask[1:0]};
        `EBI_W8:  lane_fit = {3'h0, mask[0]};
        default:  lane_fit = mask;
      endcase
    end
  endfunction

  // pin synchronisers; left out of reset so straps settle during reset
  reg [2:0]  strap_s1_r;
  reg [2:0]  strap_s2_r;
  reg        ack_s1_r;
  reg        ack_s2_r;
  reg [31:0] din_s1_r;
  reg [31:0] din_s2_r;

  always @(posedge mclk) begin
    strap_s1_r <= {strap_lane_mode, strap_clk_ratio};
    strap_s2_r <= strap_s1_r;
    ack_s1_r   <= ack_in;
    ack_s2_r   <= ack_s1_r;
    din_s1_r   <= data_in;
    din_s2_r   <= din_s1_r;
  end

  reg        boot_r;
  reg [1:0]  ratio_r;
  reg [7:0]  ctrl_r;
  reg [31:0] chcfg_r;
  reg [8:0]  cmd_r;
  reg [31:0] addr_r;
  reg [31:0] wdat_r;
  reg [31:0] rdat_r;
  reg        busy_r;
  reg        done_r;
  reg [2:0]  state_r;
  reg [3:0]  wait_r;
  reg        ack_drv_r;

  // io clock divider; one tick per io clock period
  reg  [1:0] div_r;
  reg        clk_hi_r;
  wire       tick    = (div_r == ratio_r);
  wire [1:0] div_nxt = tick ? 2'h0 : div_r + 2'h1;
  wire       clk_en  = ctrl_r[`EBI_CTRL_CLKEN];

  always @(posedge mclk) begin
    if (reset) begin
      div_r    <= 2'h0;
      clk_hi_r <= 1'b1;
    end else begin
      div_r    <= div_nxt;
      // quarter rate keeps a half duty; third rate is high one mclk in three
      clk_hi_r <= (ratio_r == `EBI_RATIO_QTR) ? ~div_nxt[1] : (div_nxt == 2'h0);
    end
  end

  // full rate passes mclk straight through, a flop cannot toggle that fast
  assign ext_io_clock = ~clk_en ? 1'b1 :
                        (ratio_r == `EBI_RATIO_FULL) ? mclk : clk_hi_r;

  // ready pin is open-drain style: only ever pulled low by the block
  assign ack_out = 1'b0;

  // axi4-lite slave
  reg        aw_hold_r;
  reg        w_hold_r;
  reg [7:0]  awaddr_r;
  reg [31:0] wbus_r;
  reg [3:0]  wstrb_r;

  assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire       do_wr  = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  wire [3:0] ch_cfg = chcfg_r[{cmd_r[`EBI_CMD_CH], 2'h0} +: 4];
  wire       cmd_wr = cmd_r[`EBI_CMD_WR];
  wire [3:0] lanes  = ~lane_fit(ch_cfg[`EBI_CH_WIDTH], cmd_r[`EBI_CMD_MASK]);
  wire       bwe    = ch_cfg[`EBI_CH_LMODE];

  // ready seen: counted wait for internal pacing, pin low for external
  wire ready = ch_cfg[`EBI_CH_EXTACK] ? ~ack_s2_r : ack_drv_r;

  always @(posedge mclk) begin
    if (reset) begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      awaddr_r     <= 8'h00;
      wbus_r       <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `EBI_RESP_OK;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `EBI_RESP_OK;
      s_axi_rdata  <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wbus_r   <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awaddr_r)
          `EBI_OFS_CTRL, `EBI_OFS_CHCFG, `EBI_OFS_CMD, `EBI_OFS_ADDR,
          `EBI_OFS_WDATA, `EBI_OFS_RDATA, `EBI_OFS_STAT: begin
            s_axi_bresp <= `EBI_RESP_OK;
          end
          default: begin
            s_axi_bresp <= `EBI_RESP_ERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `EBI_RESP_OK;
        case (s_axi_araddr)
          `EBI_OFS_CTRL:  s_axi_rdata <= {24'h00_0000, ctrl_r};
          `EBI_OFS_CHCFG: s_axi_rdata <= chcfg_r;
          `EBI_OFS_CMD:   s_axi_rdata <= {23'h00_0000, cmd_r};
          `EBI_OFS_ADDR:  s_axi_rdata <= addr_r;
          `EBI_OFS_WDATA: s_axi_rdata <= wdat_r;
          `EBI_OFS_RDATA: s_axi_rdata <= rdat_r;
          `EBI_OFS_STAT:  s_axi_rdata <= {25'h000_0000, strap_s2_r[2], ratio_r,
                                         2'h0, done_r, busy_r};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `EBI_RESP_ERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  wire wr_hit = do_wr & ~busy_r;
  wire go     = wr_hit & (awaddr_r == `EBI_OFS_CMD) & wstrb_r[1] & wbus_r[`EBI_CMD_GO];
  wire fin    = (state_r == ST_HOLD) & tick;

  // merged words for the narrow registers, cut back to register width below
  wire [31:0] ctrl_m = wmerge({24'h00_0000, ctrl_r}, wbus_r, wstrb_r);
  wire [31:0] cmd_m  = wmerge({23'h00_0000, cmd_r}, wbus_r, wstrb_r);

  // register file and external cycle sequencer
  always @(posedge mclk) begin
    if (reset) begin
      boot_r            <= 1'b0;
      ratio_r           <= `EBI_RATIO_FULL;
      ctrl_r            <= `EBI_CTRL_RST;
      chcfg_r           <= `EBI_CHCFG_RST;
      cmd_r             <= 9'h000;
      addr_r            <= 32'h0000_0000;
      wdat_r            <= 32'h0000_0000;
      rdat_r            <= 32'h0000_0000;
      busy_r            <= 1'b0;
      done_r            <= 1'b0;
      state_r           <= ST_IDLE;
      wait_r            <= 4'h0;
      ack_drv_r         <= 1'b0;
      ack_oe            <= 1'b0;
      addr_pin          <= 16'h0000;
      high_addr_latch_n <= 1'b1;
      chip_sel_n        <= `EBI_CS_NONE;
      out_en_n          <= 1'b1;
      wr_strobe_n       <= 1'b1;
      byte_lane_en_n    <= `EBI_LANE_NONE;
      data_out          <= 32'h0000_0000;
      data_oe           <= 1'b0;
    end else begin
      // straps caught on the first edge after reset release
      if (!boot_r) begin
        boot_r  <= 1'b1;
        ratio_r <= strap_s2_r[1:0];
        chcfg_r <= {8{1'b0, strap_s2_r[2], 2'h0}};
      end
      // setup writes refused while a cycle is under way
      if (wr_hit) begin
        case (awaddr_r)
          `EBI_OFS_CTRL:  ctrl_r  <= ctrl_m[7:0];
          `EBI_OFS_CHCFG: chcfg_r <= wmerge(chcfg_r, wbus_r, wstrb_r);
          `EBI_OFS_CMD:   cmd_r   <= cmd_m[8:0];
          `EBI_OFS_ADDR:  addr_r  <= wmerge(addr_r, wbus_r, wstrb_r);
          `EBI_OFS_WDATA: wdat_r  <= wmerge(wdat_r, wbus_r, wstrb_r);
          default: begin
          end
        endcase
      end
      // done is sticky; a new completion wins over the clear
      if (fin) begin
        done_r <= 1'b1;
      end else if (do_wr && awaddr_r == `EBI_OFS_STAT && wstrb_r[0] &&
                   wbus_r[`EBI_STAT_DONE]) begin
        done_r <= 1'b0;
      end
      case (state_r)
        ST_IDLE: begin
          if (go) begin
            busy_r  <= 1'b1;
            state_r <= ST_LATCH;
          end
        end
        ST_LATCH: begin
          if (tick) begin
            addr_pin          <= addr_r[31:16];
            high_addr_latch_n <= 1'b0;
            state_r           <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (tick) begin
            high_addr_latch_n <= 1'b1;
            addr_pin          <= addr_r[15:0];
            chip_sel_n        <= ~(`EBI_CS_ONE << cmd_r[`EBI_CMD_CH]);
            data_out          <= wdat_r;
            data_oe           <= cmd_wr;
            wait_r            <= ctrl_r[`EBI_CTRL_WAIT];
            state_r           <= ST_STRB;
          end
        end
        ST_STRB: begin
          out_en_n       <= cmd_wr;
          wr_strobe_n    <= ~cmd_wr;
          byte_lane_en_n <= (bwe && !cmd_wr) ? `EBI_LANE_NONE : lanes;
          if (tick) begin
            if (ready) begin
              rdat_r    <= din_s2_r;
              ack_drv_r <= 1'b0;
              ack_oe    <= 1'b0;
              state_r   <= ST_HOLD;
            end else if (!ch_cfg[`EBI_CH_EXTACK]) begin
              if (wait_r == 4'h0) begin
                ack_drv_r <= 1'b1;
                ack_oe    <= 1'b1;
              end else begin
                wait_r <= wait_r - 4'h1;
              end
            end
          end
        end
        ST_HOLD: begin
          out_en_n       <= 1'b1;
          wr_strobe_n    <= 1'b1;
          byte_lane_en_n <= `EBI_LANE_NONE;
          if (tick) begin
            chip_sel_n <= `EBI_CS_NONE;
            data_oe    <= 1'b0;
            busy_r     <= 1'b0;
            state_r    <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// *** rtl/ebi_pins_consts.vh ***
// Purpose: named constants for the external bus pin block
// Assumes: AXI4-Lite register window, 32-bit data
// Notes:   offsets are byte addresses
`ifndef EBI_PINS_CONSTS_VH
`define EBI_PINS_CONSTS_VH

`define EBI_OFS_CTRL   8'h00
`define EBI_OFS_CHCFG  8'h04
`define EBI_OFS_CMD    8'h08
`define EBI_OFS_ADDR   8'h0C
`define EBI_OFS_WDATA  8'h10
`define EBI_OFS_RDATA  8'h14
`define EBI_OFS_STAT   8'h18

`define EBI_CTRL_CLKEN 0
`define EBI_CTRL_WAIT  7:4
`define EBI_CTRL_RST   8'h20

`define EBI_CHCFG_RST  32'h0000_0000
`define EBI_CH_WIDTH   1:0
`define EBI_CH_LMODE   2
`define EBI_CH_EXTACK  3

`define EBI_CMD_CH     2:0
`define EBI_CMD_WR     3
`define EBI_CMD_MASK   7:4
`define EBI_CMD_GO     8

`define EBI_STAT_BUSY  0
`define EBI_STAT_DONE  1

`define EBI_W32        2'h0
`define EBI_W16        2'h1
`define EBI_W8         2'h2

`define EBI_RATIO_FULL 2'h0
`define EBI_RATIO_QTR  2'h3

`define EBI_RESP_OK    2'h0
`define EBI_RESP_ERR   2'h2

`define EBI_CS_ONE     8'h01
`define EBI_CS_NONE    8'hFF
`define EBI_LANE_NONE  4'hF

`endif

// *** test/ebi_dev_model.sv ***
// Purpose: one-word sram model on the external pins
// Assumes: shares mclk with the block
// Notes:   address ignored; a released bus shows the inverted last value
`timescale 1ns/10ps
module ebi_dev_model (
  input  wire        mclk,
  input  wire [7:0]  chip_sel_n,
  input  wire        out_en_n,
  input  wire        wr_strobe_n,
  input  wire [3:0]  byte_lane_en_n,
  input  wire [31:0] data_out,
  input  wire        ack_drive,
  input  wire [3:0]  ack_dly,
  output reg  [31:0] data_in,
  output wire        ack_pull
);
  reg [31:0] mem_r = 32'h0000_0000;
  reg [3:0]  cnt_r = 4'h0;
  wire       strb  = (!out_en_n || !wr_strobe_n) && chip_sel_n != 8'hff;
  integer    n;
  // slow answer: hold ready off until the delay runs out
  assign ack_pull = ack_drive && strb && cnt_r >= ack_dly;
  initial data_in = 32'h5a5a_0f0f;
  always @(posedge mclk) begin
    cnt_r <= strb ? cnt_r + 4'h1 : 4'h0;
    if (!out_en_n && chip_sel_n != 8'hff)
      data_in <= mem_r;
    else
      data_in <= ~data_in;
    for (n = 0; n < 4; n = n + 1)
      if (!wr_strobe_n && chip_sel_n != 8'hff && !byte_lane_en_n[n])
        mem_r[8*n +: 8] <= data_out[8*n +: 8];
  end
endmodule

// *** test/ebi_props_properties.sv ***
// Purpose: pin and bus checks for the external bus pin block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   region config is not visible here, so lane widths are bench checks
`timescale 1ns/10ps
module ebi_props (
  input wire       mclk,
  input wire       reset,
  input wire [7:0] chip_sel_n,
  input wire       out_en_n,
  input wire       wr_strobe_n,
  input wire       high_addr_latch_n,
  input wire [3:0] byte_lane_en_n,
  input wire       data_oe,
  input wire       ack_oe,
  input wire       ack_out,
  input wire       ext_io_clock,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  input wire       s_axi_bvalid,
  input wire       s_axi_bready,
  input wire [1:0] s_axi_bresp
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  a_idle_at_release: assert property ($fell(reset) |-> chip_sel_n == 8'hff && out_en_n &&
    wr_strobe_n && high_addr_latch_n && byte_lane_en_n == 4'hf && ext_io_clock)
    else $error("pins not idle after reset");
  a_one_select: assert property (chip_sel_n != 8'hff |-> $onehot(~chip_sel_n))
    else $error("chip select not one-hot");
  a_oe_read_only: assert property (!out_en_n |-> chip_sel_n != 8'hff && !data_oe && wr_strobe_n)
    else $error("output enable outside a read");
  a_we_drives_bus: assert property (!wr_strobe_n |-> chip_sel_n != 8'hff && data_oe)
    else $error("write strobe without data drive");
  a_lanes_strobed: assert property (byte_lane_en_n != 4'hf |-> !out_en_n || !wr_strobe_n)
    else $error("lanes active outside strobe");
  a_latch_short: assert property ($fell(high_addr_latch_n) |->
    chip_sel_n == 8'hff ##[1:4] high_addr_latch_n)
    else $error("address latch strobe wrong");
  a_ack_in_cycle: assert property (ack_oe |-> chip_sel_n != 8'hff && !ack_out)
    else $error("ready driven outside a cycle");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
    $stable(s_axi_bresp))
    else $error("write response dropped");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
endmodule
bind ebi_pins ebi_props u_props (.mclk(mclk), .reset(reset), .chip_sel_n(chip_sel_n),
  .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n), .high_addr_latch_n(high_addr_latch_n),
  .byte_lane_en_n(byte_lane_en_n), .data_oe(data_oe), .ack_oe(ack_oe), .ack_out(ack_out),
  .ext_io_clock(ext_io_clock), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp));

// *** test/testbench.sv ***
// Purpose: self-checking bench for the external bus pin block
// Assumes: straps change only under reset
// Notes:   pin behaviour is summarised per cycle and compared after it
`timescale 1ns/10ps
`include "ebi_pins_consts.vh"
module testbench;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} ebi_note_t;
  logic        mclk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, strap_lane_mode, ack_en, oe_seen, we_seen;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, cs_seen;
  logic [31:0] s_axi_wdata, lf;
  logic [3:0]  s_axi_wstrb, ack_dly, lane_seen;
  logic [1:0]  strap_clk_ratio;
  logic [15:0] hi_seen;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         ext_io_clock, high_addr_latch_n, out_en_n, wr_strobe_n, data_oe;
  wire         ack_out, ack_oe, ack_pull, ack_in;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata, data_in, data_out;
  wire [15:0]  addr_pin;
  wire [7:0]   chip_sel_n;
  wire [3:0]   byte_lane_en_n;
  ebi_note_t   rq[$];
  logic [1:0]  bq[$];
  int          err_total, check_count, rise_cnt;
  // pulled-up ready line, low if either side pulls
  assign ack_in = !((ack_oe && !ack_out) || ack_pull);
  ebi_pins DUT (.mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .strap_clk_ratio, .strap_lane_mode, .ext_io_clock, .addr_pin,
    .high_addr_latch_n, .chip_sel_n, .out_en_n, .wr_strobe_n, .byte_lane_en_n, .data_in,
    .data_out, .data_oe, .ack_in, .ack_out, .ack_oe);
  ebi_dev_model u_dev (.mclk, .chip_sel_n, .out_en_n, .wr_strobe_n, .byte_lane_en_n,
    .data_out, .ack_drive(ack_en), .ack_dly, .data_in, .ack_pull);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic to();
    err_total++;
    $display("wrong value at %0t: wait ran out", $time);
    finish_test();
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int t;
    @(posedge mclk);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (t = 0; t < 100; t++) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (t == 100) to();
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                        input logic [1:0] r, output logic [31:0] v);
    int t;
    @(posedge mclk);
    rq.push_back('{d, m, r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (t = 0; t < 100; t++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata;
    s_axi_rready <= 1'b0;
    if (t == 100) to();
  endtask
  always @(posedge ext_io_clock) rise_cnt++;
  always @(posedge mclk) begin : monitor
    ebi_note_t n;
    cs_seen &= chip_sel_n;
    lane_seen &= byte_lane_en_n;
    oe_seen &= out_en_n;
    we_seen &= wr_strobe_n;
    if (!high_addr_latch_n) hi_seen = addr_pin;
    if (s_axi_rvalid && s_axi_rready) begin
      n = rq.pop_front();
      chk(s_axi_rdata & n.m, n.d & n.m);
      chk({30'h0, s_axi_rresp}, {30'h0, n.r});
    end
    if (s_axi_bvalid && s_axi_bready) chk({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
  end
  task automatic cnt_rises(input int n);
    @(posedge mclk);
    #1 rise_cnt = 0;
    repeat (24) @(posedge mclk);
    #1 chk(rise_cnt, n);
  endtask
  task automatic ext_cyc(input logic [2:0] ch, input logic wr, input logic [3:0] mk,
                         input logic [3:0] ln, input logic [15:0] ha);
    logic [31:0] v;
    int t;
    {cs_seen, lane_seen, oe_seen, we_seen} = '1;
    axi_wr(`EBI_OFS_CMD, {23'h0, 1'b1, mk, wr, ch}, `EBI_RESP_OK);
    for (t = 0; t < 100; t++) begin
      axi_rd(`EBI_OFS_STAT, 32'h0, 32'h0, `EBI_RESP_OK, v);
      if (v[1]) break;
    end
    if (t == 100) to();
    axi_wr(`EBI_OFS_STAT, 32'h2, `EBI_RESP_OK);
    chk({24'h0, cs_seen}, {24'h0, ~(8'h1 << ch)});
    chk({28'h0, lane_seen}, {28'h0, ln});
    chk({30'h0, oe_seen, we_seen}, {30'h0, wr, !wr});
    chk({16'h0, hi_seen}, {16'h0, ha});
    $display("test ext cycle ch %0d wr %0d done", ch, wr);
  endtask
  initial begin : main
    logic [31:0] v, wd, ex;
    logic [3:0]  mk, wm;
    logic [1:0]  rt;
    int          k, t;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, ack_en, ack_dly, strap_clk_ratio} = '0;
    {strap_lane_mode, err_total, check_count, rise_cnt, ex} = '0;
    s_axi_wstrb = 4'hf;
    reset = 1'b1;
    lf = 32'h0000_0ab8;
    for (k = 0; k < 4; k++) begin
      rt = k[1:0];
      @(posedge mclk);
      reset <= 1'b1;
      strap_clk_ratio <= rt;
      strap_lane_mode <= rt[0];
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      repeat (2) @(posedge mclk);
      axi_rd(`EBI_OFS_CTRL, 32'h20, 32'hffff_ffff, `EBI_RESP_OK, v);
      axi_rd(`EBI_OFS_STAT, {25'h0, rt[0], rt, 4'h0}, 32'h73, `EBI_RESP_OK, v);
      axi_rd(`EBI_OFS_CHCFG, rt[0] ? 32'h4444_4444 : 32'h0, '1, `EBI_RESP_OK, v);
      cnt_rises(0);
      axi_wr(`EBI_OFS_CTRL, 32'h21, `EBI_RESP_OK);
      cnt_rises(24 / (k + 1));
      axi_wr(`EBI_OFS_CTRL, 32'h20, `EBI_RESP_OK);
      repeat (8) @(posedge mclk);
      cnt_rises(0);
      chk({31'h0, ext_io_clock}, 32'h1);
      $display("test io clock ratio %0d done", k);
    end
    axi_wr(8'h1c, 32'h0, `EBI_RESP_ERR);
    axi_rd(8'h1c, 32'h0, '1, `EBI_RESP_ERR, v);
    axi_wr(`EBI_OFS_CTRL, 32'h21, `EBI_RESP_OK);
    for (k = 0; k < 12; k++) begin
      lf = nxt(lf);
      wd = nxt(lf);
      mk = lf[6:3] | 4'h1;
      wm = (k % 3 == 0) ? 4'hf : (k % 3 == 1) ? 4'h3 : 4'h1;
      ack_en <= (k >= 6);
      ack_dly <= 4'h2 + {2'h0, lf[9:8]};
      axi_wr(`EBI_OFS_CHCFG, {28'h0, k >= 6, k / 3 % 2 == 1, 2'(k % 3)} << (4 * lf[2:0]),
             `EBI_RESP_OK);
      axi_wr(`EBI_OFS_ADDR, lf, `EBI_RESP_OK);
      axi_wr(`EBI_OFS_WDATA, wd, `EBI_RESP_OK);
      ext_cyc(lf[2:0], 1'b1, mk, ~(mk & wm), lf[31:16]);
      for (t = 0; t < 4; t++) if (mk[t] & wm[t]) ex[8*t +: 8] = wd[8*t +: 8];
      ext_cyc(lf[2:0], 1'b0, 4'hf, (k / 3 % 2 == 1) ? 4'hf : ~wm, lf[31:16]);
      axi_rd(`EBI_OFS_RDATA, ex, {{8{wm[3]}}, {8{wm[2]}}, {8{wm[1]}}, {8{wm[0]}}},
             `EBI_RESP_OK, v);
    end
    finish_test();
  end
endmodule
